/* common/hdc_pkg.sv */
// Constants, register map and state encoding for the H-bridge drive control block.
// Assumes a 125 MHz system clock and an AXI4-Lite register slave with 32-bit data.
package hdc_pkg;
   // Clock and timing figures.
   localparam int CLK_PERIOD_NS = 8;
   localparam int QUAL_TIME_NS = 4000;
   // Short qualification rounds up to whole cycles.
   localparam int QUAL_CYCLES = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUAL_W = 10;
   localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_CYCLES - 1);
   // Protection timer: capacitance times threshold over charge current.
   localparam int TIMER_CAP_PF = 100;
   localparam int TIMER_VTH_MV = 1000;
   localparam int TIMER_ICHG_NA = 5000;
   localparam int PROT_TIME_NS = TIMER_CAP_PF * TIMER_VTH_MV * 1000 / TIMER_ICHG_NA;
   localparam int PROT_CYCLES = PROT_TIME_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;
   localparam logic [TIMER_W-1:0] PROT_PERIOD_RST = TIMER_W'(PROT_CYCLES);
   localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;
   // Register byte offsets.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PROT_PERIOD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
   // Interrupt bit positions.
   localparam int IRQ_W = 3;
   localparam int IRQ_LIMIT = 0;
   localparam int IRQ_SHORT = 1;
   localparam int IRQ_LATCH = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   // Protection sequencer states.
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_LIMIT_BRAKE = 3'b001,
      ST_SHORT_OFF = 3'b010,
      ST_RECHECK = 3'b011,
      ST_LATCHED = 3'b100
   } hdc_state_t;
endpackage : hdc_pkg

/* core/hdc_hbridge_drive_control.sv */
// H-bridge drive control: direction decode, current-limit braking and short protection.
// Assumes all pin inputs are synchronous to clk and that the fault timer period
// register is written only while the bridge is idle.
module hdc_hbridge_drive_control
   import hdc_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Host control pins.
   input wire logic powerSaveInput,
   input wire logic directionCtlA,
   input wire logic directionCtlB,
   // Protection flags from the analog comparators.
   input wire logic currentLimitTrip,
   input wire logic shortDetectLeft,
   input wire logic shortDetectRight,
   // Bridge outputs: level and drive enable.
   output logic bridgeOutputLeft,
   output logic bridgeOutputLeftOe,
   output logic bridgeOutputRight,
   output logic bridgeOutputRightOe,
   // Interrupt.
   output logic irq,
   // AXI4-Lite write address and data.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   hdc_state_t state_reg;
   hdc_state_t state_next;
   logic shortSide_reg;
   logic [QUAL_W-1:0] qual_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [TIMER_W-1:0] period_reg;
   logic [TIMER_W-1:0] periodEff;
   logic [IRQ_W-1:0] irqStatus_reg;
   logic [IRQ_W-1:0] irqMask_reg;
   logic [IRQ_W-1:0] irqEvents;
   logic [IRQ_W-1:0] irqClear;
   logic shortSel;
   logic qualDone;
   logic timerDone;
   logic driving;
   logic lOe, lLv, rOe, rLv;
   logic wrFire;
   logic rdFire;
   logic [31:0] rdData;
   logic rdHit;
   // A zero period is treated as one cycle, the same length that a period of one gives.
   assign periodEff = (period_reg == '0) ? TIMER_ONE : period_reg;
   assign timerDone = (timer_reg <= TIMER_ONE);
   assign driving = directionCtlA ^ directionCtlB;
   // Short flag watched: either output while running, the re-enabled one on recheck.
   always_comb begin
      if (state_reg == ST_RUN) begin
         shortSel = shortDetectLeft | shortDetectRight;
      end else if (state_reg == ST_RECHECK) begin
         shortSel = shortSide_reg ? shortDetectRight : shortDetectLeft;
      end else begin
         shortSel = 1'b0;
      end
   end
   assign qualDone = shortSel && (qual_reg == QUAL_LAST);
   // Qualification counter: counts continuous detection, restarts on any gap.
   always_ff @(posedge clk) begin
      if (rst || !powerSaveInput || !shortSel || qualDone) begin
         qual_reg <= '0;
      end else begin
         qual_reg <= qual_reg + 1'b1;
      end
   end
   // Sequencer next state; power save low overrides everything.
   always_comb begin
      state_next = state_reg;
      if (!powerSaveInput) begin
         state_next = ST_RUN;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (qualDone) begin
                  state_next = ST_SHORT_OFF;
               end else if (currentLimitTrip && driving) begin
                  state_next = ST_LIMIT_BRAKE;
               end
            end
            ST_LIMIT_BRAKE: begin
               if (timerDone) begin
                  state_next = ST_RUN;
               end
            end
            ST_SHORT_OFF: begin
               if (timerDone) begin
                  state_next = ST_RECHECK;
               end
            end
            ST_RECHECK: begin
               if (qualDone) begin
                  state_next = ST_LATCHED;
               end else if (!shortSel) begin
                  state_next = ST_RUN;
               end
            end
            ST_LATCHED: state_next = ST_LATCHED;
            default: state_next = ST_RUN;
         endcase
      end
   end
   // Sequencer state and the side on which the short was seen.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_RUN;
         shortSide_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_RUN && qualDone) begin
            shortSide_reg <= !shortDetectLeft;
         end
      end
   end
   // Shared protection timer, loaded on entry to either timed state.
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_reg <= '0;
      end else if ((state_next == ST_LIMIT_BRAKE || state_next == ST_SHORT_OFF)
                   && state_next != state_reg) begin
         timer_reg <= periodEff;
      end else if (!timerDone) begin
         timer_reg <= timer_reg - TIMER_ONE;
      end
   end
   // Output decode from pins and sequencer state.
   always_comb begin
      lOe = 1'b0;
      lLv = 1'b0;
      rOe = 1'b0;
      rLv = 1'b0;
      if (!powerSaveInput || state_reg == ST_LATCHED) begin
         lOe = 1'b0;
      end else if (state_reg == ST_LIMIT_BRAKE) begin
         lOe = 1'b1;
         rOe = 1'b1;
      end else begin
         lOe = directionCtlA | directionCtlB;
         rOe = directionCtlA | directionCtlB;
         lLv = directionCtlA & !directionCtlB;
         rLv = directionCtlB & !directionCtlA;
         if (state_reg == ST_SHORT_OFF) begin
            if (shortSide_reg) begin
               rOe = 1'b0;
            end else begin
               lOe = 1'b0;
            end
         end
      end
   end
   // Registered bridge outputs.
   always_ff @(posedge clk) begin
      if (rst) begin
         bridgeOutputLeft <= 1'b0;
         bridgeOutputLeftOe <= 1'b0;
         bridgeOutputRight <= 1'b0;
         bridgeOutputRightOe <= 1'b0;
      end else begin
         bridgeOutputLeft <= lLv;
         bridgeOutputLeftOe <= lOe;
         bridgeOutputRight <= rLv;
         bridgeOutputRightOe <= rOe;
      end
   end
   // Protection events feeding the interrupt status.
   assign irqEvents[IRQ_LIMIT] = (state_reg == ST_RUN) && (state_next == ST_LIMIT_BRAKE);
   assign irqEvents[IRQ_SHORT] = (state_reg == ST_RUN) && (state_next == ST_SHORT_OFF);
   assign irqEvents[IRQ_LATCH] = (state_reg == ST_RECHECK) && (state_next == ST_LATCHED);
   // AXI write channel: address and data taken together, one response at a time.
   assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wrFire;
   assign s_axi_wready = wrFire;
   assign irqClear = (wrFire && s_axi_awaddr == OFS_IRQ_STATUS && s_axi_wstrb[0]) ?
                     s_axi_wdata[IRQ_W-1:0] : IRQ_RST;
   // Write response.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (s_axi_awaddr == OFS_PROT_PERIOD || s_axi_awaddr == OFS_IRQ_STATUS ||
                         s_axi_awaddr == OFS_IRQ_MASK || s_axi_awaddr == OFS_MODE_STATUS) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // Writable registers: protection period and interrupt mask.
   always_ff @(posedge clk) begin
      if (rst) begin
         period_reg <= PROT_PERIOD_RST;
         irqMask_reg <= IRQ_RST;
      end else if (wrFire) begin
         if (s_axi_awaddr == OFS_PROT_PERIOD) begin
            if (s_axi_wstrb[0]) begin
               period_reg[7:0] <= s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
               period_reg[15:8] <= s_axi_wdata[15:8];
            end
         end
         if (s_axi_awaddr == OFS_IRQ_MASK && s_axi_wstrb[0]) begin
            irqMask_reg <= s_axi_wdata[IRQ_W-1:0];
         end
      end
   end
   // Sticky interrupt status: a new event wins over a write-one clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         irqStatus_reg <= IRQ_RST;
      end else begin
         irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
      end
   end
   assign irq = |(irqStatus_reg & irqMask_reg);
   // Read decode.
   always_comb begin
      rdData = DATA_ZERO;
      rdHit = 1'b1;
      case (s_axi_araddr)
         OFS_MODE_STATUS: begin
            rdData[2:0] = state_reg;
            rdData[3] = shortSide_reg;
            rdData[4] = bridgeOutputLeftOe;
            rdData[5] = bridgeOutputLeft;
            rdData[6] = bridgeOutputRightOe;
            rdData[7] = bridgeOutputRight;
         end
         OFS_PROT_PERIOD: rdData[TIMER_W-1:0] = period_reg;
         OFS_IRQ_STATUS: rdData[IRQ_W-1:0] = irqStatus_reg;
         OFS_IRQ_MASK: rdData[IRQ_W-1:0] = irqMask_reg;
         default: rdHit = 1'b0;
      endcase
   end
   // Read channel: one read at a time, data registered.
   assign s_axi_arready = !s_axi_rvalid;
   assign rdFire = s_axi_arvalid && !s_axi_rvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= DATA_ZERO;
         s_axi_rresp <= RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdData;
         s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // Helper: cycles spent so far in the current timed state.
   logic [TIMER_W-1:0] dwell_reg;
   always_ff @(posedge clk) begin
      if (rst || state_next != state_reg) begin
         dwell_reg <= '0;
      end else begin
         dwell_reg <= dwell_reg + TIMER_ONE;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Checks on the drive decode and the protection sequence.
   a_standby_outputs_off: assert property (
      !powerSaveInput |=> !bridgeOutputLeftOe && !bridgeOutputRightOe)
      else $error("Bridge driven while power save is low.");
   a_forward_decode: assert property (
      powerSaveInput && directionCtlA && !directionCtlB && state_reg == ST_RUN
      |=> bridgeOutputLeftOe && bridgeOutputLeft && bridgeOutputRightOe && !bridgeOutputRight)
      else $error("Forward decode wrong.");
   a_brake_decode: assert property (
      powerSaveInput && directionCtlA && directionCtlB && state_reg == ST_RUN
      |=> bridgeOutputLeftOe && !bridgeOutputLeft && bridgeOutputRightOe && !bridgeOutputRight)
      else $error("Brake decode wrong.");
   a_limit_enters_brake: assert property (
      powerSaveInput && state_reg == ST_RUN && !qualDone && currentLimitTrip && driving
      |=> state_reg == ST_LIMIT_BRAKE ##1 !bridgeOutputLeft && bridgeOutputLeftOe)
      else $error("Current limit trip did not brake.");
   a_timed_state_length: assert property (
      powerSaveInput && (state_reg == ST_LIMIT_BRAKE || state_reg == ST_SHORT_OFF)
      && state_next != state_reg |-> dwell_reg + TIMER_ONE == $past(periodEff, 1))
      else $error("Protection interval length differs from the timer period.");
   a_short_qualified: assert property (
      $rose(state_reg == ST_SHORT_OFF) |-> $past(qual_reg) == QUAL_LAST)
      else $error("Short acted on before qualification.");
   a_short_side_off: assert property (
      powerSaveInput && state_reg == ST_SHORT_OFF && (directionCtlA || directionCtlB)
      |=> bridgeOutputLeftOe == shortSide_reg && bridgeOutputRightOe == !shortSide_reg)
      else $error("Wrong output turned off after short.");
   a_recheck_follows: assert property (
      state_reg == ST_SHORT_OFF && powerSaveInput && timerDone |=> state_reg == ST_RECHECK)
      else $error("Output not re-enabled after timer.");
   a_latch_holds: assert property (
      state_reg == ST_LATCHED && powerSaveInput |=> state_reg == ST_LATCHED
      ##1 !bridgeOutputLeftOe && !bridgeOutputRightOe)
      else $error("Latched standby released without power save.");
   a_latch_release: assert property (
      state_reg == ST_LATCHED && !powerSaveInput |=> state_reg == ST_RUN)
      else $error("Power save low did not clear the latch.");
   c_forward_run: cover property (
      state_reg == ST_RUN && bridgeOutputLeft && bridgeOutputLeftOe [*4]);
   c_limit_brake: cover property ($fell(state_reg == ST_LIMIT_BRAKE));
   c_short_recover: cover property (state_reg == ST_RECHECK ##1 state_reg == ST_RUN);
   c_short_latch: cover property (state_reg == ST_RECHECK ##1 state_reg == ST_LATCHED);
endmodule : hdc_hbridge_drive_control

/* verification/hdc_motor_model.sv */
// Behavioural brushed motor and fault source across the two bridge outputs.
// Assumes the bench commands overload and output shorts, synchronous to clk.
module hdc_motor_model (
   // Clock.
   input wire logic clk,
   // Bridge side.
   input wire logic leftOut,
   input wire logic leftOe,
   input wire logic rightOut,
   input wire logic rightOe,
   // Bench commands.
   input wire logic overloadCmd,
   input wire logic shortLeftCmd,
   input wire logic shortRightCmd,
   // Comparator flags towards the bridge logic.
   output logic currentLimitTrip = 1'b0,
   output logic shortDetectLeft = 1'b0,
   output logic shortDetectRight = 1'b0
);
   // Winding current flows only while opposite levels are driven; flags are registered.
   always @(posedge clk) begin
      currentLimitTrip <= overloadCmd && leftOe && rightOe && (leftOut != rightOut);
      shortDetectLeft <= shortLeftCmd;
      shortDetectRight <= shortRightCmd;
   end
endmodule : hdc_motor_model

/* verification/test_hbridge_drive_control.sv */
// Self-checking bench for the H-bridge drive control with a motor model.
// Assumes the AXI4-Lite slave answers one cycle after taking a request.
module test_hbridge_drive_control
   import hdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, powerSaveInput = 1'b0, directionCtlA = 1'b0;
   logic directionCtlB = 1'b0, ovl = 1'b0, shL = 1'b0, shR = 1'b0, bad;
   logic currentLimitTrip, shortDetectLeft, shortDetectRight, irq;
   logic bridgeOutputLeft, bridgeOutputLeftOe, bridgeOutputRight, bridgeOutputRightOe;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int nFail = 0, checksDone = 0, n, p;
   integer seed = 32'h3e29_cec8;

   // Design and far-side motor.
   hdc_hbridge_drive_control dut (.clk, .rst, .powerSaveInput, .directionCtlA, .directionCtlB,
      .currentLimitTrip, .shortDetectLeft, .shortDetectRight, .bridgeOutputLeft,
      .bridgeOutputLeftOe, .bridgeOutputRight, .bridgeOutputRightOe, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   hdc_motor_model motor (.clk, .leftOut(bridgeOutputLeft), .leftOe(bridgeOutputLeftOe),
      .rightOut(bridgeOutputRight), .rightOe(bridgeOutputRightOe), .overloadCmd(ovl),
      .shortLeftCmd(shL), .shortRightCmd(shR), .currentLimitTrip, .shortDetectLeft,
      .shortDetectRight);

   // Clock of 8 ns period.
   initial begin
      forever #4 clk = ~clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         nFail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Counts an exhausted wait as a mismatch and closes the run.
   task automatic hang(input string what);
      nFail++;
      $display("[FAIL] %s expected done seen timeout", what);
      finish_test();
   endtask : hang

   // Bridge state as seen at the pins; a level only counts while driven.
   function automatic logic [3:0] seen();
      return {bridgeOutputLeftOe, bridgeOutputLeftOe & bridgeOutputLeft,
         bridgeOutputRightOe, bridgeOutputRightOe & bridgeOutputRight};
   endfunction : seen

   // Expected bridge state from the control pins alone.
   function automatic logic [3:0] expBr(input logic ps, input logic a, input logic b);
      if (!ps || (!a && !b)) begin
         return 4'h0;
      end
      return {1'b1, a & !b, 1'b1, b & !a};
   endfunction : expBr

   // One AXI4-Lite write; channels are sampled at the falling edge before they are taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            s_axi_bready <= 1'b0;
            return;
         end
      end
      hang("write");
   endtask : axw

   // One AXI4-Lite read.
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int k = 0; k < 100; k++) begin
         @(negedge clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      hang("read");
   endtask : axr

   // Sets the host pins and waits until the bridge shows their effect.
   task automatic pins(input logic ps, input logic a, input logic b);
      @(posedge clk);
      powerSaveInput <= ps;
      directionCtlA <= a;
      directionCtlB <= b;
      @(posedge clk);
      @(negedge clk);
   endtask : pins

   // Counts falling edges until the bridge shows a pattern.
   task automatic waitBr(input logic [3:0] pat, output int cnt);
      for (cnt = 1; cnt < 1000; cnt++) begin
         @(negedge clk);
         if (seen() === pat) return;
      end
      hang("bridge");
   endtask : waitBr

   // Counts how many falling edges a pattern lasts, the current one included.
   task automatic lasts(input logic [3:0] pat, output int cnt);
      for (cnt = 1; cnt < 1000; cnt++) begin
         @(negedge clk);
         if (seen() !== pat) return;
      end
      hang("hold");
   endtask : lasts

   // Main sequence: reset, registers, decode, limit braking, shorts and latch.
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("bridgeReset", 4'h0, seen());
      axr(OFS_PROT_PERIOD, rd, rs);
      chk("periodReset", 32'h0000_09C4, rd);
      axr(OFS_IRQ_MASK, rd, rs);
      chk("maskReset", DATA_ZERO, rd);
      axr(8'h10, rd, rs);
      chk("unmappedResp", RESP_SLVERR, rs);
      chk("unmappedData", DATA_ZERO, rd);
      axw(8'h14, 32'h0000_0001, rs);
      chk("unmappedWrite", RESP_SLVERR, rs);
      axw(OFS_MODE_STATUS, 32'h0000_00FF, rs);
      chk("statusWrite", RESP_OKAY, rs);
      for (n = 0; n < 48; n++) begin
         p = (n < 8) ? n : $random(seed);
         pins(p[0], p[1], p[2]);
         chk("decode", expBr(p[0], p[1], p[2]), seen());
      end
      p = 4 + ($random(seed) & 7);
      axw(OFS_PROT_PERIOD, 32'(p), rs);
      axr(OFS_PROT_PERIOD, rd, rs);
      chk("period", 32'(p), rd);
      axw(OFS_IRQ_MASK, 32'h0000_0006, rs);
      pins(1'b1, 1'b1, 1'b0);
      ovl <= 1'b1;
      waitBr(4'hA, n);
      ovl <= 1'b0;
      lasts(4'hA, n);
      chk("brakeLen", 32'(p), 32'(n));
      chk("afterBrake", 4'hE, seen());
      axr(OFS_IRQ_STATUS, rd, rs);
      chk("limitEvent", 32'h0000_0001, rd);
      chk("irqMasked", 1'b0, irq);
      axw(OFS_IRQ_MASK, 32'h0000_0007, rs);
      @(negedge clk);
      chk("irqRaised", 1'b1, irq);
      axw(OFS_IRQ_STATUS, 32'h0000_0001, rs);
      @(negedge clk);
      chk("irqCleared", 1'b0, irq);
      pins(1'b1, 1'b0, 1'b1);
      shR <= 1'b1;
      bad = 1'b0;
      for (n = 0; n < 300; n++) begin
         @(negedge clk);
         if (n == 200) shR <= 1'b0;
         if (seen() !== 4'hB) bad = 1'b1;
      end
      chk("transientShort", 1'b0, bad);
      shR <= 1'b1;
      waitBr(4'h8, n);
      chk("qualDelay", 1'b1, n >= 500 && n <= 504);
      shR <= 1'b0;
      lasts(4'h8, n);
      chk("shortOffLen", 32'(p), 32'(n));
      repeat (p + 5) @(negedge clk);
      chk("recovered", 4'hB, seen());
      pins(1'b1, 1'b1, 1'b0);
      shL <= 1'b1;
      waitBr(4'h2, n);
      chk("leftOnlyOff", 1'b1, n >= 500 && n <= 504);
      lasts(4'h2, n);
      chk("leftOffLen", 32'(p), 32'(n));
      chk("leftRedriven", 4'hE, seen());
      waitBr(4'h0, n);
      chk("latchDelay", 1'b1, n >= 497 && n <= 504);
      axr(OFS_MODE_STATUS, rd, rs);
      chk("latchState", 32'h0000_0004, {29'h0, rd[2:0]});
      axr(OFS_IRQ_STATUS, rd, rs);
      chk("shortEvents", 32'h0000_0006, rd);
      chk("irqShort", 1'b1, irq);
      pins(1'b1, 1'b0, 1'b1);
      shL <= 1'b0;
      repeat (20) @(negedge clk);
      chk("latchHeld", 4'h0, seen());
      pins(1'b0, 1'b0, 1'b1);
      chk("standby", 4'h0, seen());
      pins(1'b1, 1'b0, 1'b1);
      chk("latchReleased", 4'hB, seen());
      finish_test();
   end

   // Cuts a hung run short.
   initial begin
      repeat (100000) @(posedge clk);
      hang("run");
   end
endmodule : test_hbridge_drive_control
